// ### include/debounce_regs.vh
`ifndef DEBOUNCE_REGS_VH
`define DEBOUNCE_REGS_VH

// Clock period and filter time base, in ns
`define DB_CLK_NS        10
`define DB_TICK_NS       500

// Latch mode codes
`define LM_OFF           3'h0
`define LM_RISE_AUTO     3'h1
`define LM_FALL_AUTO     3'h2
`define LM_BOTH_AUTO     3'h3
`define LM_RISE_MAN      3'h4
`define LM_FALL_MAN      3'h5
`define LM_BOTH_MAN      3'h6
`define LM_RESET         3'h0

// Debounce time selection codes
`define DT_0             4'h0
`define DT_500N          4'h1
`define DT_1U            4'h2
`define DT_2U            4'h3
`define DT_5U            4'h4
`define DT_10U           4'h5
`define DT_50U           4'h6
`define DT_100U          4'h7
`define DT_250U          4'h8
`define DT_500U          4'h9
`define DT_1M            4'ha
`define DT_2M            4'hb
`define DT_4M            4'hc
`define DT_12M           4'hd
`define DT_RESET         4'hc

// Debounce times in ns
`define DB_T1_NS         500
`define DB_T2_NS         1000
`define DB_T3_NS         2000
`define DB_T4_NS         5000
`define DB_T5_NS         10000
`define DB_T6_NS         50000
`define DB_T7_NS         100000
`define DB_T8_NS         250000
`define DB_T9_NS         500000
`define DB_T10_NS        1000000
`define DB_T11_NS        2000000
`define DB_T12_NS        4000000
`define DB_T13_NS        12000000

`define DB_CNT_W         15

`endif

// ### rtl/debounce_filter.v
`timescale 1ns/1ps
`include "debounce_regs.vh"

// One channel of the input filter with edge pulses of the accepted level
module debounce_filter #(
  parameter CNT_W = `DB_CNT_W
) (
  input  wire             sys_clk_i,  // Module clock
  input  wire             resetn_i,   // Async reset, active low
  input  wire             tick_i,     // Time base enable pulse
  input  wire             din_i,      // Synchronised raw input
  input  wire [CNT_W-1:0] limit_i,    // Ticks the new level must last
  output reg              level_o,    // Accepted level
  output reg              rise_o,     // Accepted rising edge, one cycle
  output reg              fall_o      // Accepted falling edge, one cycle
);

  reg [CNT_W-1:0] cnt_q;

  // Count ticks while the raw level differs; any return restarts the wait
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q   <= {CNT_W{1'b0}};
      level_o <= 1'b0;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (din_i == level_o) begin
        cnt_q <= {CNT_W{1'b0}};
      end else if ((limit_i == {CNT_W{1'b0}}) ||
                   (tick_i && (cnt_q >= limit_i))) begin
        // Level has outlasted the filter time
        level_o <= din_i;
        rise_o  <= din_i;
        fall_o  <= ~din_i;
        cnt_q   <= {CNT_W{1'b0}};
      end else if (tick_i) begin
        cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// ### rtl/input_debounce_pulse_latch.v
`timescale 1ns/1ps
`include "debounce_regs.vh"

// Overview of operation
// - With latching on, catch every qualifying pulse, even a short one.
// - Mode 0 off, 1-3 rise/fall/both auto, 4-6 same with manual ack.
// - Manual modes hold until acknowledge; auto modes clear at the scan.
// - Accept a new level only once it outlasts the debounce time.
// - Debounce choices 0 to 12 ms in fourteen steps.
// - Reset defaults: latching off, debounce time 4 ms.
module input_debounce_pulse_latch #(
  parameter CHANNELS    = 8,
  parameter TICK_CYCLES = `DB_TICK_NS / `DB_CLK_NS
) (
  input  wire                sys_clk_i,              // Module clock 100 MHz
  input  wire                resetn_i,               // Async reset, low
  input  wire [CHANNELS-1:0] field_in_i,             // Raw field inputs
  input  wire                cfg_load_i,             // Config write strobe
  input  wire [2:0]          latch_mode_i,           // Latch mode to load
  input  wire [3:0]          input_debounce_time_i,  // Debounce code to load
  input  wire                scan_i,                 // Network scan strobe
  input  wire [CHANNELS-1:0] ack_i,                  // Manual ack, per channel
  output reg  [2:0]          latch_mode_o,           // Active latch mode
  output reg  [3:0]          input_debounce_time_o,  // Active debounce code
  output reg  [CHANNELS-1:0] scan_value_o,           // Levels at last scan
  output reg  [CHANNELS-1:0] scan_latch_o,           // Latches at last scan
  output reg                 scan_valid_o,           // Scan result pulse
  output reg  [CHANNELS-1:0] latch_o                 // Live latch flags
);

  localparam CNT_W = `DB_CNT_W;
  localparam TW    = 16;

  // Filter limits in time-base ticks, derived from the times in ns
  // Kept at full width here; the uses cut them to the counter on purpose
  localparam [31:0] LIM1  = `DB_T1_NS  / `DB_TICK_NS;
  localparam [31:0] LIM2  = `DB_T2_NS  / `DB_TICK_NS;
  localparam [31:0] LIM3  = `DB_T3_NS  / `DB_TICK_NS;
  localparam [31:0] LIM4  = `DB_T4_NS  / `DB_TICK_NS;
  localparam [31:0] LIM5  = `DB_T5_NS  / `DB_TICK_NS;
  localparam [31:0] LIM6  = `DB_T6_NS  / `DB_TICK_NS;
  localparam [31:0] LIM7  = `DB_T7_NS  / `DB_TICK_NS;
  localparam [31:0] LIM8  = `DB_T8_NS  / `DB_TICK_NS;
  localparam [31:0] LIM9  = `DB_T9_NS  / `DB_TICK_NS;
  localparam [31:0] LIM10 = `DB_T10_NS / `DB_TICK_NS;
  localparam [31:0] LIM11 = `DB_T11_NS / `DB_TICK_NS;
  localparam [31:0] LIM12 = `DB_T12_NS / `DB_TICK_NS;
  localparam [31:0] LIM13 = `DB_T13_NS / `DB_TICK_NS;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  reg  [CHANNELS-1:0] sync1_q;
  reg  [CHANNELS-1:0] sync2_q;
  reg  [TW-1:0]       div_q;
  reg                 tick_q;
  reg  [CNT_W-1:0]    limit;
  reg                 mode_ok;
  reg                 sel_ok;
  reg                 edge_rise;
  reg                 edge_fall;
  reg                 manual;
  wire [CHANNELS-1:0] level;
  wire [CHANNELS-1:0] rise;
  wire [CHANNELS-1:0] fall;
  wire [CHANNELS-1:0] hit;
  wire [CHANNELS-1:0] clr;
  wire [CHANNELS-1:0] latch_d;

  // Field pins are asynchronous; two flops before anything looks at them
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q <= {CHANNELS{1'b0}};
      sync2_q <= {CHANNELS{1'b0}};
    end else begin
      sync1_q <= field_in_i;
      sync2_q <= sync1_q;
    end
  end

  // Time base divider: one enable pulse per filter step
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q  <= {TW{1'b0}};
      tick_q <= 1'b0;
    end else if (div_q == TICK_LAST[TW-1:0]) begin
      div_q  <= {TW{1'b0}};
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + {{(TW-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end

  // Validity of the codes offered at a configuration write
  always @* begin
    mode_ok = (latch_mode_i <= `LM_BOTH_MAN);
    sel_ok  = (input_debounce_time_i <= `DT_12M);
  end

  // Configuration holds; invalid codes leave the old setting in place
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_mode_o          <= `LM_RESET;
      input_debounce_time_o <= `DT_RESET;
    end else if (cfg_load_i) begin
      if (mode_ok) begin
        latch_mode_o <= latch_mode_i;
      end
      if (sel_ok) begin
        input_debounce_time_o <= input_debounce_time_i;
      end
    end
  end

  // Debounce code to tick limit
  always @* begin
    case (input_debounce_time_o)
      `DT_0:    limit = {CNT_W{1'b0}};
      `DT_500N: limit = LIM1[CNT_W-1:0];
      `DT_1U:   limit = LIM2[CNT_W-1:0];
      `DT_2U:   limit = LIM3[CNT_W-1:0];
      `DT_5U:   limit = LIM4[CNT_W-1:0];
      `DT_10U:  limit = LIM5[CNT_W-1:0];
      `DT_50U:  limit = LIM6[CNT_W-1:0];
      `DT_100U: limit = LIM7[CNT_W-1:0];
      `DT_250U: limit = LIM8[CNT_W-1:0];
      `DT_500U: limit = LIM9[CNT_W-1:0];
      `DT_1M:   limit = LIM10[CNT_W-1:0];
      `DT_2M:   limit = LIM11[CNT_W-1:0];
      `DT_4M:   limit = LIM12[CNT_W-1:0];
      `DT_12M:  limit = LIM13[CNT_W-1:0];
      default:  limit = LIM12[CNT_W-1:0];
    endcase
  end

  // Latch mode decode into edge choice and acknowledge style
  always @* begin
    edge_rise = 1'b0;
    edge_fall = 1'b0;
    manual    = 1'b0;
    case (latch_mode_o)
      `LM_RISE_AUTO: edge_rise = 1'b1;
      `LM_FALL_AUTO: edge_fall = 1'b1;
      `LM_BOTH_AUTO: begin
        edge_rise = 1'b1;
        edge_fall = 1'b1;
      end
      `LM_RISE_MAN: begin
        edge_rise = 1'b1;
        manual    = 1'b1;
      end
      `LM_FALL_MAN: begin
        edge_fall = 1'b1;
        manual    = 1'b1;
      end
      `LM_BOTH_MAN: begin
        edge_rise = 1'b1;
        edge_fall = 1'b1;
        manual    = 1'b1;
      end
      default: begin
        edge_rise = 1'b0;
        edge_fall = 1'b0;
        manual    = 1'b0;
      end
    endcase
  end

  // One filter per channel
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : ch
      debounce_filter #(
        .CNT_W (CNT_W)
      ) u_filt (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .tick_i    (tick_q),
        .din_i     (sync2_q[g]),
        .limit_i   (limit),
        .level_o   (level[g]),
        .rise_o    (rise[g]),
        .fall_o    (fall[g])
      );
    end
  endgenerate

  // Qualifying edges and the release condition for each latch
  assign hit = (rise & {CHANNELS{edge_rise}}) |
               (fall & {CHANNELS{edge_fall}});
  assign clr = manual ? ack_i :
               {CHANNELS{scan_i}};
  // A set in the clear cycle wins, so no edge is ever dropped
  assign latch_d = hit | (latch_o & ~clr);

  // Latch flags; latching off empties them
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_o <= {CHANNELS{1'b0}};
    end else if (!(edge_rise | edge_fall)) begin
      latch_o <= {CHANNELS{1'b0}};
    end else begin
      latch_o <= latch_d;
    end
  end

  // Scan snapshot: the scan sees the latch before its own auto release
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scan_value_o <= {CHANNELS{1'b0}};
      scan_latch_o <= {CHANNELS{1'b0}};
      scan_valid_o <= 1'b0;
    end else begin
      scan_valid_o <= scan_i;
      if (scan_i) begin
        scan_value_o <= level;
        scan_latch_o <= latch_o | hit;
      end
    end
  end

endmodule

// ### tb/idpl_assertions.sv
`timescale 1ns/1ps
// Watches channel 0; all channels share one structure
module idpl_checker #(
  parameter CHANNELS = 8
) (
  input wire                sys_clk_i,              // Clock
  input wire                resetn_i,               // Reset
  input wire                cfg_load_i,             // Load
  input wire [2:0]          latch_mode_i,           // Mode in
  input wire [3:0]          input_debounce_time_i,  // Time in
  input wire                scan_i,                 // Scan
  input wire [CHANNELS-1:0] ack_i,                  // Ack
  input wire [2:0]          latch_mode_o,           // Mode
  input wire [3:0]          input_debounce_time_o,  // Time
  input wire [CHANNELS-1:0] scan_latch_o,           // Scan latches
  input wire                scan_valid_o,           // Valid
  input wire [CHANNELS-1:0] latch_o                 // Latches
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // Manual modes; a load may switch mode, so loads are left out below
  wire manual = latch_mode_o >= 3'h4 && latch_mode_o <= 3'h6;
  AST_SCAN_LATCH: assert property (
    scan_i && !cfg_load_i && latch_o[0] |=> scan_valid_o && scan_latch_o[0])
    else $error("scan lost a latched edge");
  AST_MODE_OFF: assert property (
    (latch_mode_o == 3'h0) [*2] |-> latch_o == '0)
    else $error("latch set while mode off");
  AST_MODE_LOAD: assert property (
    cfg_load_i && latch_mode_i != 3'h7 |=> latch_mode_o == $past(latch_mode_i))
    else $error("mode not loaded");
  AST_MAN_HOLD: assert property (
    manual && latch_o[0] && !ack_i[0] && !cfg_load_i |=> latch_o[0])
    else $error("manual latch dropped");
  AST_RESET_DEF: assert property (
    $rose(resetn_i) |-> latch_mode_o == 3'h0 && input_debounce_time_o == 4'hc)
    else $error("bad reset defaults");
  AST_TIME_LOAD: assert property (
    cfg_load_i && input_debounce_time_i <= 4'hd
    |=> input_debounce_time_o == $past(input_debounce_time_i))
    else $error("time code not loaded");
  AST_TIME_BAD: assert property (
    cfg_load_i && input_debounce_time_i > 4'hd |=> $stable(input_debounce_time_o))
    else $error("bad time code taken");
  AST_ACK_CLEAR: assert property (
    manual && $stable(latch_mode_o) && $fell(latch_o[0]) |-> $past(ack_i[0]))
    else $error("manual latch cleared without ack");
endmodule
bind input_debounce_pulse_latch idpl_checker #(.CHANNELS(CHANNELS)) chk (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cfg_load_i(cfg_load_i),
  .latch_mode_i(latch_mode_i), .input_debounce_time_i(input_debounce_time_i),
  .scan_i(scan_i), .ack_i(ack_i), .latch_mode_o(latch_mode_o),
  .input_debounce_time_o(input_debounce_time_o), .scan_latch_o(scan_latch_o),
  .scan_valid_o(scan_valid_o), .latch_o(latch_o));

// ### tb/field_source.sv
`timescale 1ns/1ps
// Field contact: one clean high pulse of a chosen width per request
module field_source (
  input  wire       sys_clk_i,  // Clock
  input  wire       fire_i,     // Start a pulse
  input  wire [7:0] width_i,    // Width in cycles
  output wire       field_o     // Contact level
);
  reg [7:0] left_q = 8'h00;
  // Width may be far below a scan period, so a scan can miss its level
  always @(posedge sys_clk_i) begin
    if (fire_i)
      left_q <= width_i;
    else if (left_q != 8'h00)
      left_q <= left_q - 8'h01;
  end
  assign field_o = (left_q != 8'h00);
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg        clk = 1'b0;
  reg        rstn = 1'b0;
  reg        load = 1'b0;
  reg  [2:0] mode = 3'h0;
  reg  [3:0] dtime = 4'h0;
  reg        scan = 1'b0;
  reg  [7:0] ack = 8'h00;
  reg        fire = 1'b0;
  reg  [7:0] width = 8'h00;
  wire       field;
  wire [2:0] lmode;
  wire [3:0] dcode;
  wire [7:0] sval, slat, lat;
  wire       svld;
  integer    bad_count = 0, checked = 0, cyc = 0, m;
  // Short time base: two cycles a tick keeps filter runs brief
  input_debounce_pulse_latch #(.CHANNELS(8), .TICK_CYCLES(2)) dut (
    .sys_clk_i(clk), .resetn_i(rstn), .field_in_i({8{field}}),
    .cfg_load_i(load), .latch_mode_i(mode), .input_debounce_time_i(dtime),
    .scan_i(scan), .ack_i(ack), .latch_mode_o(lmode),
    .input_debounce_time_o(dcode), .scan_value_o(sval),
    .scan_latch_o(slat), .scan_valid_o(svld), .latch_o(lat));
  field_source src (.sys_clk_i(clk), .fire_i(fire), .width_i(width),
    .field_o(field));
  always #5 clk = ~clk;
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      bad_count = bad_count + 1;
      give_verdict;
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Waits end 1 ns past the edge so outputs have settled
  task wt(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task cfg(input [2:0] m_in, input [3:0] d_in);
    begin
      @(posedge clk);
      load <= 1'b1;
      mode <= m_in;
      dtime <= d_in;
      @(posedge clk);
      load <= 1'b0;
      #1;
    end
  endtask
  // One-cycle scan; its result pulse must stand just after it
  task do_scan;
    begin
      @(posedge clk);
      scan <= 1'b1;
      @(posedge clk);
      scan <= 1'b0;
      #1;
      chk({7'h00, svld}, 8'h01);
    end
  endtask
  // One-cycle acknowledge on the chosen channels
  task do_ack(input [7:0] a);
    begin
      @(posedge clk);
      ack <= a;
      @(posedge clk);
      ack <= 8'h00;
      #1;
    end
  endtask
  task pulse(input [7:0] w);
    begin
      @(posedge clk);
      fire <= 1'b1;
      width <= w;
      @(posedge clk);
      fire <= 1'b0;
      #1;
    end
  endtask
  task t_config;
    begin
      wt(2);
      chk({5'h00, lmode}, 8'h00);
      chk({4'h0, dcode}, 8'h0c);
      for (m = 0; m < 8; m = m + 1) begin
        cfg(m[2:0], 4'hc);
        chk({5'h00, lmode}, (m == 7) ? 8'h06 : m[7:0]);
      end
      for (m = 0; m < 16; m = m + 1) begin
        cfg(3'h0, m[3:0]);
        chk({4'h0, dcode}, (m > 13) ? 8'h0d : m[7:0]);
      end
      $display("test config done");
    end
  endtask
  // Each of modes 1 to 6 sees rise then fall; then two scans and an ack
  task t_edges;
    begin
      for (m = 1; m < 7; m = m + 1) begin
        cfg(m[2:0], 4'h0);
        pulse(8'd12);
        wt(8);
        chk(lat, {8{m % 3 != 2}});
        wt(12);
        chk(lat, 8'hff);
        do_scan;
        chk(slat, 8'hff);
        chk(lat, (m < 4) ? 8'h00 : 8'hff);
        do_scan;
        chk(slat, (m < 4) ? 8'h00 : 8'hff);
        do_ack(8'hff);
        chk(lat, 8'h00);
        chk({7'h00, svld}, 8'h00);
      end
      $display("test edges done");
    end
  endtask
  // An edge in the cycle of an ack or a scan wins over the clear
  task t_rearm;
    begin
      cfg(3'h4, 4'h0);
      pulse(8'd4);
      repeat (2) @(posedge clk);
      do_ack(8'hff);
      chk(lat, 8'hff);
      do_ack(8'h0f);
      chk(lat, 8'hf0);
      do_scan;
      chk(slat, 8'hf0);
      do_ack(8'hf0);
      chk(lat, 8'h00);
      cfg(3'h1, 4'h0);
      pulse(8'd4);
      repeat (2) @(posedge clk);
      do_scan;
      chk(slat, 8'hff);
      chk(lat, 8'hff);
      do_scan;
      chk(slat, 8'hff);
      chk(lat, 8'h00);
      $display("test rearm done");
    end
  endtask
  // Bounce shorter than the filter is dropped, a long level is taken
  task t_filter;
    begin
      cfg(3'h3, 4'h3);
      pulse(8'd3);
      wt(20);
      chk(lat, 8'h00);
      pulse(8'd40);
      wt(20);
      do_scan;
      chk(sval, 8'hff);
      wt(40);
      chk(lat, 8'hff);
      cfg(3'h0, 4'hc);
      wt(2);
      chk(lat, 8'h00);
      $display("test filter done");
    end
  endtask
  task give_verdict;
    begin
      $display("Checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_config;
    t_edges;
    t_rearm;
    t_filter;
    give_verdict;
  end
endmodule
